// File: verilog/pds_pkg.sv
package pds_pkg;
  localparam int unsigned SAMPLE_W = 12;
  localparam int unsigned OFFSET_W = 8;
  localparam logic [11:0] ALL_ONES = 12'hFFF;
  localparam logic [11:0] PIX_RST = 12'h000;
  localparam logic [7:0] OFFSET_RST = 8'h00;
  typedef enum logic [1:0] {
    PDS_SHIFT_NONE,
    PDS_SHIFT_ONCE,
    PDS_SHIFT_TWICE,
    PDS_SHIFT_THREE
  } pds_shift_t;
  typedef enum logic [1:0] {
    PDS_DEPTH_12,
    PDS_DEPTH_10,
    PDS_DEPTH_8,
    PDS_DEPTH_RSVD
  } pds_depth_t;
endpackage : pds_pkg

// File: verilog/pds_top.sv
module pds_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration from the host command decoder
  input wire logic [1:0] cfg_shift,
  input wire logic [1:0] cfg_depth,
  input wire logic [7:0] cfg_offset,
  // Sample stream from the converter
  input wire logic in_valid,
  output logic in_ready,
  input wire logic in_sof,
  input wire logic [11:0] in_sample,
  // Pixel stream to the frame grabber
  output logic out_valid,
  input wire logic out_ready,
  output logic out_sof,
  output logic [11:0] out_pixel,
  // Settings in force for the current frame
  output logic [1:0] act_shift,
  output logic [1:0] act_depth,
  output logic [7:0] act_offset
);
  // ****************************************
  // Reset release
  // ****************************************
  // The pin reset takes hold at once but lets go only after two edges, so no
  // flop leaves reset on an edge that the rise of the pin could straddle.
  logic rst_s1_q;
  logic rst_s2_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'h0;
      rst_s2_q <= 1'h0;
    end else begin
      rst_s1_q <= 1'h1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_sync_n = rst_s2_q;

  // ****************************************
  // Frame-latched settings
  // ****************************************
  // Settings are latched only with the first sample of a frame, so a host
  // command arriving mid-frame never splits one image across two windows.
  logic [1:0] shift_q;
  logic [1:0] depth_q;
  logic [7:0] offset_q;
  wire take_in = in_valid && in_ready;
  wire latch_cfg = take_in && in_sof;
  wire [1:0] shift_use = latch_cfg ? cfg_shift : shift_q;
  wire [1:0] depth_use = latch_cfg ? cfg_depth : depth_q;
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      shift_q <= pds_pkg::PDS_SHIFT_NONE;
      depth_q <= pds_pkg::PDS_DEPTH_12;
      offset_q <= pds_pkg::OFFSET_RST;
    end else if (latch_cfg) begin
      shift_q <= cfg_shift;
      depth_q <= cfg_depth;
      offset_q <= cfg_offset;
    end
  end

  // ****************************************
  // Bit window selection
  // ****************************************
  // One window per shift step: step s lifts the sample by s places. A sample
  // bit lifted past the top of the word saturates the window, so an over-bright
  // pixel clips to white instead of wrapping round to a dark value.
  wire [3:0] ovf;
  wire [11:0] lifted [4];
  wire [11:0] win12 [4];
  wire [9:0] win10 [4];
  wire [7:0] win8 [4];
  for (genvar s = 0; s < 4; s++) begin : g_win
    if (s == 0) begin : g_flat
      // Nothing leaves the word when no shift is selected.
      assign ovf[s] = 1'h0;
    end else begin : g_lift
      assign ovf[s] = |in_sample[11 -: s];
    end
    assign lifted[s] = in_sample << s;
    // Twelve-bit depth keeps the whole lifted word, zeros filling the bottom.
    assign win12[s] = ovf[s] ? pds_pkg::ALL_ONES : lifted[s];
    // Narrower depths take the top of the lifted word, right-justified.
    assign win10[s] = ovf[s] ? 10'h3FF : lifted[s][11:2];
    assign win8[s] = ovf[s] ? 8'hFF : lifted[s][11:4];
  end

  // Selection follows the settings in force for this sample.
  wire [11:0] sel12 = win12[shift_use];
  wire [9:0] sel10 = win10[shift_use];
  wire [7:0] sel8 = win8[shift_use];
  // The reserved depth code is treated as twelve-bit.
  wire [11:0] pix_sel = (depth_use == pds_pkg::PDS_DEPTH_10) ? {2'b00, sel10} :
                        (depth_use == pds_pkg::PDS_DEPTH_8) ? {4'h0, sel8} : sel12;

  // ****************************************
  // Two-entry output buffer
  // ****************************************
  // Two slots let in_ready come from a flop while still running at full rate.
  logic [12:0] mem_q [2];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  // The head is always on show, so a pop is exactly an output handshake.
  wire take_out = out_valid && out_ready;
  wire [12:0] in_word = {in_sof, pix_sel};
  assign cnt_d = cnt_q + {1'h0, take_in} - {1'h0, take_out};

  // Each slot is written only when the write pointer names it.
  for (genvar e = 0; e < 2; e++) begin : g_slot
    wire slot_wr = take_in && (wr_ptr_q == 1'(e));
    always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        mem_q[e] <= {1'h0, pds_pkg::PIX_RST};
      end else if (slot_wr) begin
        mem_q[e] <= in_word;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_ptr_q <= 1'h0;
    end else if (take_in) begin
      wr_ptr_q <= ~wr_ptr_q;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rd_ptr_q <= 1'h0;
    end else if (take_out) begin
      rd_ptr_q <= ~rd_ptr_q;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  // A word written into the slot that is about to become the head bypasses
  // the slot, so a pixel shows one edge after its sample is taken.
  wire rd_next = take_out ? ~rd_ptr_q : rd_ptr_q;
  wire head_bypass = take_in && (cnt_d == 2'h1) && (rd_next == wr_ptr_q);
  wire [12:0] head_d = head_bypass ? in_word : mem_q[rd_next];
  wire out_valid_d = (cnt_d != 2'h0);
  // Ready drops as the second slot fills, so a stalled receiver loses no
  // word; the price is that ready follows one edge behind each pop.
  wire in_ready_d = (cnt_d != 2'h2);
  wire [7:0] offset_use = latch_cfg ? cfg_offset : offset_q;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      out_valid <= 1'h0;
    end else begin
      out_valid <= out_valid_d;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      in_ready <= 1'h0;
    end else begin
      in_ready <= in_ready_d;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      out_sof <= 1'h0;
    end else begin
      out_sof <= head_d[12];
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      out_pixel <= pds_pkg::PIX_RST;
    end else begin
      out_pixel <= head_d[11:0];
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      act_shift <= pds_pkg::PDS_SHIFT_NONE;
    end else begin
      act_shift <= shift_use;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      act_depth <= pds_pkg::PDS_DEPTH_12;
    end else begin
      act_depth <= depth_use;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      act_offset <= pds_pkg::OFFSET_RST;
    end else begin
      act_offset <= offset_use;
    end
  end
endmodule // pds_top

// File: verif/pds_properties.sv
module pds_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Sample side
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic in_sof,
  input wire logic [1:0] cfg_shift,
  input wire logic [7:0] cfg_offset,
  // Pixel side
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic out_sof,
  input wire logic [11:0] out_pixel,
  // Settings in force
  input wire logic [1:0] act_shift,
  input wire logic [1:0] act_depth,
  input wire logic [7:0] act_offset
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic tk = in_valid && in_ready;
  wire logic hd = out_valid && out_sof;
  property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_pixel); endproperty
  a_hold: assert property (p_hold) else $error("pixel lost in stall");
  property p_ans; tk && !out_valid |=> out_valid; endproperty
  a_ans: assert property (p_ans) else $error("no pixel after sample");
  property p_upd; tk && in_sof |=> act_offset == $past(cfg_offset); endproperty
  a_upd: assert property (p_upd) else $error("offset not taken");
  property p_shf; tk && in_sof |=> act_shift == $past(cfg_shift); endproperty
  a_shf: assert property (p_shf) else $error("shift not taken");
  property p_keep; !(tk && in_sof) |=> $stable(act_shift) && $stable(act_depth); endproperty
  a_keep: assert property (p_keep) else $error("setting moved in frame");
  property p_s3; hd && act_depth == 2'h0 && act_shift == 2'h3 |-> !out_pixel[2:0] || &out_pixel;
  endproperty
  a_s3: assert property (p_s3) else $error("bad low bits");
  property p_s2; hd && act_depth == 2'h0 && act_shift == 2'h2 |-> !out_pixel[1:0] || &out_pixel;
  endproperty
  a_s2: assert property (p_s2) else $error("bad low bits");
  property p_d10; hd && act_depth == 2'h1 |-> out_pixel[11:10] == 2'h0; endproperty
  a_d10: assert property (p_d10) else $error("ten bit overflow");
  property p_d8; hd && act_depth == 2'h2 |-> out_pixel[11:8] == 4'h0; endproperty
  a_d8: assert property (p_d8) else $error("eight bit overflow");
endmodule // pds_properties

// File: verif/pds_grabber.sv
module pds_grabber (
  // Clock
  input wire logic clk,
  // Pixel stream from the block
  input wire logic out_valid,
  input wire logic out_sof,
  input wire logic [11:0] out_pixel,
  output logic out_ready,
  // Stall request from the bench
  input wire logic stall
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [12:0] got[$];
  initial out_ready = 1'h0;
  // Ready moves off the sampling edge so the block never sees it change mid-edge.
  always @(negedge clk) out_ready <= !stall;
  always @(posedge clk) if (out_valid && out_ready) got.push_back({out_sof, out_pixel});
endmodule // pds_grabber

// File: verif/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = '0, rst_n = '0, in_valid = '0, in_sof = '0, stall = '0;
  logic [1:0] cfg_shift = '0, cfg_depth = '0, act_shift, act_depth;
  logic [7:0] cfg_offset = '0, act_offset;
  logic [11:0] in_sample = '0, out_pixel;
  logic in_ready, out_valid, out_ready, out_sof;
  logic [11:0] smp[5] = '{12'h1A5, 12'h200, 12'h400, 12'h800, 12'hFFF};
  int mismatches = 0, checks_done = 0, cyc = 0;
  always #5 clk = !clk;
  pds_top uut (.*);
  pds_grabber grab (.*);
  function automatic logic [11:0] expv(logic [1:0] d, logic [1:0] n, logic [11:0] v);
    int w = (d == 2'h1) ? 10 : (d == 2'h2) ? 8 : 12;
    if (n != 2'h0 && (v >> (12 - n)) != 0) return 12'hFFF >> (12 - w);
    return ((v << n) & 12'hFFF) >> (12 - w);
  endfunction
  task automatic chk(logic [12:0] seen, logic [12:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(logic sof, logic [11:0] v);
    @(negedge clk);
    {in_valid, in_sof, in_sample} = {1'h1, sof, v};
    do @(posedge clk); while (in_ready !== 1'h1);
    @(negedge clk);
    in_valid = 1'h0;
  endtask
  task automatic pop(logic [12:0] e);
    for (int i = 0; i < 9 && grab.got.size() == 0; i++) @(negedge clk);
    chk(13'(grab.got.size() != 0), 13'h0001);
    if (grab.got.size() != 0) chk(grab.got.pop_front(), e);
  endtask
  task automatic t_modes();
    for (int d = 0; d < 4; d++) for (int n = 0; n < 4; n++) foreach (smp[k]) begin
      {cfg_depth, cfg_shift, cfg_offset} = {2'(d), 2'(n), smp[k][11:4]};
      send(1'h1, smp[k]);
      pop({1'h1, expv(2'(d), 2'(n), smp[k])});
      chk({5'h0, act_offset}, {5'h0, smp[k][11:4]});
      chk({9'h0, act_depth, act_shift}, {9'h0, 2'(d), 2'(n)});
    end
    $display("test modes done");
  endtask
  task automatic t_frame();
    {cfg_depth, cfg_shift} = 4'h0;
    send(1'h1, 12'h123);
    pop({1'h1, 12'h123});
    cfg_shift = 2'h2;
    send(1'h0, 12'h123);
    pop({1'h0, 12'h123});
    chk({11'h0, act_shift}, 13'h0000);
    send(1'h1, 12'h123);
    pop({1'h1, 12'h48C});
    chk({11'h0, act_shift}, 13'h0002);
    $display("test frame done");
  endtask
  task automatic t_stall();
    stall = 1'h1;
    send(1'h0, 12'h001);
    send(1'h0, 12'h002);
    @(negedge clk);
    chk({12'h0, in_ready}, 13'h0000);
    fork begin repeat (5) @(negedge clk); stall = 1'h0; end join_none
    send(1'h0, 12'h003);
    for (int i = 1; i < 4; i++) pop(13'(i * 4));
    $display("test stall done");
  endtask
  task automatic t_reset();
    @(negedge clk);
    rst_n = 1'h0;
    @(negedge clk);
    chk({9'h0, out_valid, in_ready, act_shift}, 13'h0000);
    rst_n = 1'h1;
    repeat (2) @(negedge clk);
    chk({12'h0, in_ready}, 13'h0000);
    @(negedge clk);
    chk({12'h0, in_ready}, 13'h0001);
    send(1'h0, 12'h0F1);
    pop({1'h0, 12'h0F1});
    $display("test reset done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) if (++cyc > 5000) begin mismatches++; end_sim(); end
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'h1;
    t_modes();
    t_frame();
    t_stall();
    t_reset();
    end_sim();
  end
endmodule // tb
bind pds_top pds_properties chk (.*);
